/* hw/otpsr_pkg.sv */
// Constants shared by the security register command logic and its testbench
package otpsr_pkg;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SEC_PROGRAM  = 8'h9B;
    localparam logic [7:0] OP_SEC_READ     = 8'h4B;
    localparam logic [7:0] OP_READ_SR1     = 8'h05;
    localparam logic [7:0] OP_READ_SR2     = 8'h35;
    localparam logic [7:0] OP_READ_SR3     = 8'h15;

    // ------------------------------------------------------------------
    // Security register layout
    // ------------------------------------------------------------------
    localparam int         SEC_ADDR_W    = 9;
    localparam int         SEC_REG_BYTES = 128;
    localparam int         SEC_REG_COUNT = 4;
    localparam int         SEC_MEM_BYTES = SEC_REG_BYTES * SEC_REG_COUNT;
    localparam int         SEC_SEL_LSB   = 7;
    localparam int         SEC_TOP_BYTE  = SEC_REG_BYTES - 1;
    localparam logic [7:0] SEC_ERASED    = 8'hFF;
    // Seed of the factory content of register 0; value is arbitrary
    localparam logic [7:0] FACTORY_SEED  = 8'h5A;

    // ------------------------------------------------------------------
    // Frame bit counts
    // ------------------------------------------------------------------
    localparam logic [5:0] BITS_CMD       = 6'h08;
    localparam logic [5:0] BITS_ADDR_LAST = 6'h1F;
    localparam logic [5:0] BITS_ADDR_END  = 6'h20;
    localparam logic [5:0] BITS_DUMMY_END = 6'h28;
    localparam logic [5:0] BITS_CMD_LAST  = 6'h07;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int SR1_BUSY_BIT = 0;
    localparam int SR1_WEL_BIT  = 1;
    localparam int SR2_LOCK_LSB = 3;

    // ------------------------------------------------------------------
    // Buffers and timing
    // ------------------------------------------------------------------
    localparam int PGM_BUF_DEPTH   = 256;
    localparam int RD_FIFO_DEPTH   = 8;
    localparam int CLK_MHZ         = 50;
    localparam int SEC_PGM_TIME_US = 200;
    localparam int SEC_PGM_CYCLES  = SEC_PGM_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {PGM_IDLE, PGM_WAIT, PGM_WRITE} otpsr_state_t;

endpackage

/* hw/otpsr_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module otpsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wrPtr_ff;
    logic [PW-1:0]    rdPtr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign inReady  = (count_ff != (PW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = store[rdPtr_ff];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            store[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else if (flush)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_ff <= (wrPtr_ff == PW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (pop)
            begin
                rdPtr_ff <= (rdPtr_ff == PW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule

/* hw/otpsr_core.sv */
// SPI command logic for the security registers and direct status reads
`timescale 1ns/1ps
module otpsr_core
    import otpsr_pkg::*;
#(
    parameter int PGM_CYCLES = SEC_PGM_CYCLES,
    parameter int BUF_DEPTH  = PGM_BUF_DEPTH,
    parameter int FIFO_DEPTH = RD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // SPI pins
    input  wire logic       spiCsN,
    input  wire logic       spiSck,
    input  wire logic       spiSi,
    output logic            spiSoOut,
    output logic            spiSoOe,
    // Status bits
    output logic            readyBusyFlag,
    output logic            writeEnableLatch,
    output logic [2:0]      securityLockBits
);
    localparam int BW = $clog2(BUF_DEPTH);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic csnS1_ff, csnS2_ff, csnDly_ff;
    logic sckS1_ff, sckS2_ff, sckDly_ff;
    logic siS1_ff, siS2_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            csnS1_ff  <= 1'b1;
            csnS2_ff  <= 1'b1;
            csnDly_ff <= 1'b1;
            sckS1_ff  <= 1'b0;
            sckS2_ff  <= 1'b0;
            sckDly_ff <= 1'b0;
            siS1_ff   <= 1'b0;
            siS2_ff   <= 1'b0;
        end
        else
        begin
            csnS1_ff  <= spiCsN;
            csnS2_ff  <= csnS1_ff;
            csnDly_ff <= csnS2_ff;
            sckS1_ff  <= spiSck;
            sckS2_ff  <= sckS1_ff;
            sckDly_ff <= sckS2_ff;
            siS1_ff   <= spiSi;
            siS2_ff   <= siS1_ff;
        end
    end

    logic csLow, sckRise, sckFall, csRise;
    assign csLow   = ~csnS2_ff;
    assign sckRise = csLow & sckS2_ff & ~sckDly_ff;
    assign sckFall = csLow & ~sckS2_ff & sckDly_ff;
    assign csRise  = csnS2_ff & ~csnDly_ff;

    // ------------------------------------------------------------------
    // Frame bit counting and input shifting
    // ------------------------------------------------------------------
    logic [5:0]      bitCnt_ff;
    logic [2:0]      bitPos_ff;
    logic [7:0]      inShift_ff;
    logic [7:0]      cmd_ff;
    logic [8:0]      addr_ff;
    logic [7:0]      inByte;
    logic            byteDone;
    otpsr_state_t    state_ff;
    logic            busy;

    assign inByte   = {inShift_ff[6:0], siS2_ff};
    assign byteDone = sckRise & (bitPos_ff == 3'h7);
    assign busy     = (state_ff != PGM_IDLE);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bitCnt_ff <= '0;
            bitPos_ff <= '0;
        end
        else if (csnS2_ff)
        begin
            bitCnt_ff <= '0;
            bitPos_ff <= '0;
        end
        else if (sckRise)
        begin
            bitPos_ff <= bitPos_ff + 3'h1;
            bitCnt_ff <= (bitCnt_ff == BITS_DUMMY_END) ? bitCnt_ff : bitCnt_ff + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            inShift_ff <= '0;
            cmd_ff     <= '0;
            addr_ff    <= '0;
        end
        else
        begin
            if (sckRise)
            begin
                inShift_ff <= inByte;
            end
            if (sckRise && bitCnt_ff == BITS_CMD_LAST)
            begin
                cmd_ff <= inByte;
            end
            if (sckRise && bitCnt_ff >= BITS_CMD && bitCnt_ff <= BITS_ADDR_LAST)
            begin
                addr_ff <= {addr_ff[7:0], siS2_ff};
            end
        end
    end

    logic cmdIn;
    assign cmdIn = (bitCnt_ff >= BITS_CMD);

    // ------------------------------------------------------------------
    // Program data buffer
    // ------------------------------------------------------------------
    logic [7:0] pgmBuf [BUF_DEPTH];
    logic [BW:0] pgmCnt_ff;
    logic        takeData;

    assign takeData = byteDone & (bitCnt_ff >= BITS_ADDR_END) & (cmd_ff == OP_SEC_PROGRAM) & ~busy;

    always_ff @(posedge clk)
    begin
        if (takeData)
        begin
            pgmBuf[pgmCnt_ff[BW-1:0]] <= inByte;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pgmCnt_ff <= '0;
        end
        else if (csnS2_ff)
        begin
            pgmCnt_ff <= '0;
        end
        else if (takeData && pgmCnt_ff != (BW+1)'(BUF_DEPTH))
        begin
            pgmCnt_ff <= pgmCnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // End-of-frame decisions
    // ------------------------------------------------------------------
    function automatic logic regLocked(input logic [1:0] sel, input logic [2:0] lock);
        regLocked = (sel == 2'h0) ? 1'b1 : lock[sel - 2'h1];
    endfunction

    logic pgmFrame, pgmIncomplete, pgmStart, weSet, weClr;
    logic [2:0] lockBits_ff;

    assign pgmFrame      = csRise & cmdIn & (cmd_ff == OP_SEC_PROGRAM) & ~busy;
    assign pgmIncomplete = pgmFrame & ((bitCnt_ff < BITS_ADDR_END) | (bitPos_ff != 3'h0));
    assign pgmStart      = pgmFrame & ~pgmIncomplete & writeEnableLatch
                         & ~regLocked(addr_ff[8:7], lockBits_ff)
                         & (pgmCnt_ff != '0);
    assign weSet = csRise & (bitCnt_ff == BITS_CMD) & (bitPos_ff == 3'h0)
                 & (cmd_ff == OP_WRITE_ENABLE) & ~busy;
    assign weClr = pgmIncomplete | pgmStart;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            writeEnableLatch <= 1'b0;
        end
        else if (weSet)
        begin
            writeEnableLatch <= 1'b1;
        end
        else if (weClr)
        begin
            writeEnableLatch <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Program engine and security memory
    // ------------------------------------------------------------------
    logic [7:0]  secMem [SEC_MEM_BYTES];
    logic [23:0] waitCnt_ff;
    logic [BW:0] idx_ff;
    logic [BW:0] pgmLen_ff;
    logic [8:0]  pgmAddr_ff;
    logic [8:0]  wrAddr;

    assign wrAddr        = pgmAddr_ff + 9'(idx_ff);
    assign readyBusyFlag = busy;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff   <= PGM_IDLE;
            waitCnt_ff <= '0;
            idx_ff     <= '0;
            pgmLen_ff  <= '0;
            pgmAddr_ff <= '0;
        end
        else
        begin
            case (state_ff)
                PGM_IDLE:
                begin
                    if (pgmStart)
                    begin
                        state_ff   <= PGM_WAIT;
                        waitCnt_ff <= '0;
                        pgmLen_ff  <= pgmCnt_ff;
                        pgmAddr_ff <= addr_ff;
                    end
                end
                PGM_WAIT:
                begin
                    if (waitCnt_ff == 24'(PGM_CYCLES - 1))
                    begin
                        state_ff <= PGM_WRITE;
                        idx_ff   <= '0;
                    end
                    else
                    begin
                        waitCnt_ff <= waitCnt_ff + 24'h00_0001;
                    end
                end
                PGM_WRITE:
                begin
                    if (idx_ff == pgmLen_ff - 1'b1)
                    begin
                        state_ff <= PGM_IDLE;
                    end
                    else
                    begin
                        idx_ff <= idx_ff + 1'b1;
                    end
                end
                default:
                begin
                    state_ff <= PGM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < SEC_MEM_BYTES; i++)
            begin
                secMem[i] <= (i < SEC_REG_BYTES) ? (FACTORY_SEED ^ 8'(i)) : SEC_ERASED;
            end
        end
        else if (state_ff == PGM_WRITE && !regLocked(wrAddr[8:7], lockBits_ff))
        begin
            // Bytes that run into a locked register, register 0 included, are skipped
            // Only bits driven to zero change, so repeated passes can only clear more bits
            secMem[wrAddr] <= secMem[wrAddr] & pgmBuf[idx_ff[BW-1:0]];
        end
    end

    generate
        for (genvar k = 1; k < SEC_REG_COUNT; k++)
        begin : g_lock
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    lockBits_ff[k-1] <= 1'b0;
                end
                else
                begin
                    lockBits_ff[k-1] <= (secMem[k*SEC_REG_BYTES + SEC_TOP_BYTE] != SEC_ERASED);
                end
            end
        end
    endgenerate

    assign securityLockBits = lockBits_ff;

    // ------------------------------------------------------------------
    // Read prefetch into the FIFO
    // ------------------------------------------------------------------
    logic       fetchEn_ff;
    logic       rdMode_ff;
    logic [8:0] fetchAddr_ff;
    logic       fifoInReady, fifoOutValid, fifoPop;
    logic [7:0] fifoOutData;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fetchEn_ff   <= 1'b0;
            rdMode_ff    <= 1'b0;
            fetchAddr_ff <= '0;
        end
        else if (csnS2_ff)
        begin
            fetchEn_ff <= 1'b0;
            rdMode_ff  <= 1'b0;
        end
        else if (sckRise && bitCnt_ff == BITS_ADDR_LAST && cmd_ff == OP_SEC_READ && !busy)
        begin
            fetchEn_ff   <= 1'b1;
            rdMode_ff    <= 1'b1;
            fetchAddr_ff <= {addr_ff[7:0], siS2_ff};
        end
        else if (fetchEn_ff && fifoInReady)
        begin
            fetchAddr_ff <= fetchAddr_ff + 9'h001;
        end
    end

    otpsr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .flush    (csnS2_ff),
        .inValid  (fetchEn_ff),
        .inReady  (fifoInReady),
        .inData   (secMem[fetchAddr_ff]),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    function automatic logic [7:0] statusByte(input logic [7:0] op, input logic bsy,
                                              input logic write_enable_latch, input logic [2:0] lock);
        statusByte = 8'h00;
        if (op == OP_READ_SR1)
        begin
            statusByte[SR1_BUSY_BIT] = bsy;
            statusByte[SR1_WEL_BIT]  = write_enable_latch;
        end
        else if (op == OP_READ_SR2)
        begin
            statusByte[SR2_LOCK_LSB +: 3] = lock;
        end
    endfunction

    logic stMode, outPhase, loadByte;
    logic [7:0] soShift_ff;
    logic [7:0] nxt_byte;

    assign stMode   = cmdIn & ((cmd_ff == OP_READ_SR1) | (cmd_ff == OP_READ_SR2)
                    | (cmd_ff == OP_READ_SR3));
    assign outPhase = (rdMode_ff & (bitCnt_ff == BITS_DUMMY_END)) | stMode;
    assign loadByte = sckFall & outPhase & (bitPos_ff == 3'h0);
    assign fifoPop  = loadByte & rdMode_ff;
    assign nxt_byte = rdMode_ff ? (fifoOutValid ? fifoOutData : SEC_ERASED)
                    : statusByte(cmd_ff, busy, writeEnableLatch, lockBits_ff);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            soShift_ff <= '0;
            spiSoOut   <= 1'b0;
            spiSoOe    <= 1'b0;
        end
        else if (csnS2_ff)
        begin
            spiSoOe <= 1'b0;
        end
        else if (loadByte)
        begin
            soShift_ff <= nxt_byte;
            spiSoOut   <= nxt_byte[7];
            spiSoOe    <= 1'b1;
        end
        else if (sckFall && outPhase)
        begin
            soShift_ff <= {soShift_ff[6:0], 1'b0};
            spiSoOut   <= soShift_ff[6];
        end
    end

endmodule

/* test/otpsr_monitor.sv */
// Port-level assertions for the security register command logic
`timescale 1ns/1ps
module otpsr_monitor
    import otpsr_pkg::*;
#(
    parameter int PGM_CYCLES = SEC_PGM_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // SPI pins
    input wire logic       spiCsN,
    input wire logic       spiSck,
    input wire logic       spiSi,
    input wire logic       spiSoOut,
    input wire logic       spiSoOe,
    // Status bits
    input wire logic       readyBusyFlag,
    input wire logic       writeEnableLatch,
    input wire logic [2:0] securityLockBits
);
    logic [19:0] busyCnt_ff;

    // Length of the current busy period
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            busyCnt_ff <= 20'h0_0000;
        else if (readyBusyFlag)
            busyCnt_ff <= busyCnt_ff + 20'h0_0001;
        else
            busyCnt_ff <= 20'h0_0000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_csIdle; spiCsN [*6]; endsequence
    sequence s_busyStart; $rose(readyBusyFlag); endsequence

    property p_soRelease; s_csIdle |-> !spiSoOe; endproperty
    property p_soStart; $rose(spiSoOe) |-> !spiCsN && !spiSck; endproperty
    property p_soShift;
        $changed(spiSoOut) && spiSoOe && $past(spiSoOe) |-> !spiSck && !$past(spiSck);
    endproperty
    property p_lockSticky; ($past(securityLockBits) & ~securityLockBits) == 3'h0; endproperty
    property p_lockWhenBusy;
        $changed(securityLockBits) |-> $past(readyBusyFlag) || $past(readyBusyFlag, 3);
    endproperty
    property p_welClear; s_busyStart |-> !writeEnableLatch; endproperty
    property p_welBusy; readyBusyFlag |-> !writeEnableLatch; endproperty
    property p_busyCause; s_busyStart |-> spiCsN && $past(spiCsN, 2); endproperty
    property p_busyLen;
        $fell(readyBusyFlag) |-> busyCnt_ff >= PGM_CYCLES && busyCnt_ff <= PGM_CYCLES + 260;
    endproperty

    a_soRelease: assert property (p_soRelease)
        else $error("output still enabled while deselected");
    a_soStart: assert property (p_soStart)
        else $error("output enabled off a clock fall");
    a_soShift: assert property (p_soShift)
        else $error("output bit changed off a clock fall");
    a_lockSticky: assert property (p_lockSticky)
        else $error("lock bit cleared");
    a_lockWhenBusy: assert property (p_lockWhenBusy)
        else $error("lock bit changed outside programming");
    a_welClear: assert property (p_welClear)
        else $error("write enable set at program start");
    a_welBusy: assert property (p_welBusy)
        else $error("write enable set while busy");
    a_busyCause: assert property (p_busyCause)
        else $error("busy started while selected");
    a_busyLen: assert property (p_busyLen)
        else $error("busy period has wrong length");
endmodule

bind otpsr_core otpsr_monitor #(.PGM_CYCLES(PGM_CYCLES)) i_monitor (.clk, .sys_rst, .spiCsN,
    .spiSck, .spiSi, .spiSoOut, .spiSoOe, .readyBusyFlag, .writeEnableLatch, .securityLockBits);

/* test/otpsr_host_model.sv */
// Host SPI controller model, mode 0, driving at the falling clock edge
`timescale 1ns/1ps
module otpsr_host_model (
    // Clock
    input  wire logic clk,
    // SPI pins
    output logic      spiCsN,
    output logic      spiSck,
    output logic      spiSi,
    input  wire logic spiSoOut,
    input  wire logic spiSoOe
);
    initial
    begin
        spiCsN = 1'b1;
        spiSck = 1'b0;
        spiSi  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic start();
        tick(1);
        spiCsN = 1'b0;
        tick(3);
    endtask

    // Serial clock stands low and input toggles while deselected
    task automatic stop();
        tick(4);
        spiCsN = 1'b1;
        spiSi  = ~spiSi;
        tick(6);
    endtask

    task automatic shift(input logic [31:0] v, input int n, output logic [31:0] rx);
        rx = 32'h0000_0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            spiSi = v[i];
            tick(4);
            spiSck = 1'b1;
            // A released output line shows the inverse of its last value
            rx = {rx[30:0], spiSoOe ? spiSoOut : ~spiSoOut};
            tick(4);
            spiSck = 1'b0;
        end
    endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the security register command logic
`timescale 1ns/1ps
module tb_top;
    import otpsr_pkg::*;
    localparam int PGM = 300;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       spiCsN, spiSck, spiSi, spiSoOut, spiSoOe;
    logic       readyBusyFlag, writeEnableLatch;
    logic [2:0] securityLockBits;
    logic [7:0] expMem [SEC_MEM_BYTES];
    logic [7:0] ops [3] = '{OP_READ_SR1, OP_READ_SR2, OP_READ_SR3};
    int         err_count = 0;
    int         total_checks = 0;

    always #10 clk = ~clk;

    otpsr_core #(.PGM_CYCLES(PGM)) i_dut (.clk, .sys_rst, .spiCsN, .spiSck, .spiSi, .spiSoOut,
        .spiSoOe, .readyBusyFlag, .writeEnableLatch, .securityLockBits);
    otpsr_host_model i_host (.clk, .spiCsN, .spiSck, .spiSi, .spiSoOut, .spiSoOe);

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register 0 always counts as locked, the others once their top byte is programmed
    function automatic logic isLocked(input logic [8:0] x);
        return x[8:7] == 2'h0 || expMem[{x[8:7], 7'h7F}] != 8'hFF;
    endfunction

    function automatic logic [7:0] expStatus(input int idx, input logic write_enable_latch);
        logic [2:0] lk;
        for (int k = 0; k < 3; k++)
            lk[k] = (expMem[k * 128 + 255] != 8'hFF);
        case (idx)
            0: return {6'h00, write_enable_latch, 1'b0};
            1: return {2'h0, lk, 3'h0};
            default: return 8'h00;
        endcase
    endfunction

    task automatic rdStatus(input int idx, output logic [7:0] s);
        logic [31:0] rx;
        i_host.start();
        i_host.shift({24'h00_0000, ops[idx]}, 8, rx);
        i_host.shift(32'h0000_0000, 8, rx);
        i_host.stop();
        s = rx[7:0];
    endtask

    task automatic rdSec(input logic [8:0] a, input int n);
        logic [31:0] rx;
        i_host.start();
        i_host.shift({24'h00_0000, OP_SEC_READ}, 8, rx);
        i_host.shift({8'h00, 15'($urandom), a}, 24, rx);
        i_host.shift(32'h0000_0000, 8, rx);
        for (int i = 0; i < n; i++)
        begin
            i_host.shift(32'h0000_0000, 8, rx);
            check(rx[7:0], expMem[9'(a + i)]);
        end
        i_host.stop();
    endtask

    // Program n bytes, then cut extra bits off the byte boundary
    task automatic prog(input logic [8:0] a, input int n, input int cut);
        logic [31:0] rx;
        logic [7:0]  d;
        logic [7:0]  s;
        logic        ok;
        logic        write_enable_latch;
        ok = cut == 0 && n > 0 && !isLocked(a);
        write_enable_latch = ok ? 1'b0 : (cut == 0);
        rdStatus(0, s);
        i_host.start();
        i_host.shift({24'h00_0000, OP_WRITE_ENABLE}, 8, rx);
        i_host.stop();
        i_host.start();
        i_host.shift({24'h00_0000, OP_SEC_PROGRAM}, 8, rx);
        i_host.shift({8'h00, 15'($urandom), a}, 24, rx);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom) & 8'h7F;
            i_host.shift({24'h00_0000, d}, 8, rx);
            if (ok && !isLocked(9'(a + i)))
                expMem[9'(a + i)] &= d;
        end
        i_host.shift(32'h0000_0000, cut, rx);
        i_host.stop();
        check({7'h00, writeEnableLatch}, {7'h00, write_enable_latch});
        check({7'h00, readyBusyFlag}, {7'h00, ok});
        rdStatus(0, s);
        check(s, {6'h00, write_enable_latch, ok});
        for (int i = 0; i < 8 && s[0] === 1'b1; i++)
            rdStatus(0, s);
        check(s, expStatus(0, write_enable_latch));
        check({5'h00, securityLockBits}, expStatus(1, 1'b0) >> 3);
    endtask

    initial
    begin
        repeat (80000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        logic [7:0] s;
        logic [8:0] a;
        logic [31:0] rx;
        for (int i = 0; i < SEC_MEM_BYTES; i++)
            expMem[i] = (i < 128) ? (FACTORY_SEED ^ 8'(i)) : SEC_ERASED;
        void'($urandom(32'h72e7_c9b8));
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rdStatus(i, s);
            check(s, expStatus(i, 1'b0));
        end
        rdSec(9'h07C, 8);
        rdSec(9'h1FE, 4);
        prog(9'h005, 2, 0);
        rdSec(9'h005, 2);
        a = 9'h080 + 9'($urandom_range(100));
        prog(a, 3, 0);
        prog(a, 3, 0);
        rdSec(a, 3);
        prog(9'h100, 2, 3);
        rdSec(9'h100, 2);
        prog(9'h17F, 1, 0);
        rdStatus(1, s);
        check(s, 8'h10);
        prog(9'h100, 2, 0);
        rdSec(9'h100, 2);
        repeat (6)
        begin
            a = 9'($urandom);
            prog(a, 1 + $urandom_range(3), 0);
            rdSec(a, 4);
        end
        i_host.start();
        i_host.shift({21'h00_0000, OP_READ_SR1, 3'h0}, 11, rx);
        check({7'h00, spiSoOe}, 8'h01);
        i_host.stop();
        check({7'h00, spiSoOe}, 8'h00);
        print_verdict();
    end
endmodule
